// ==== pkg/fps_pkg.sv ====
// constants for the parallel flash host sequencer
package fps_pkg;
  localparam int unsigned clk_period_ns = 50;
  // bus cycle phases in ns, rounded up to clock cycles, read access plus one cycle (write pulse, recovery, read access)
  localparam int unsigned wr_pulse_ns = 30;
  localparam int unsigned wr_high_ns = 30;
  localparam int unsigned oe_high_ns = 50;
  localparam int unsigned rd_access_ns = 55;
  localparam int unsigned wr_pulse_cyc = (wr_pulse_ns + clk_period_ns - 1) / clk_period_ns;
  localparam int unsigned wr_high_cyc = (wr_high_ns + clk_period_ns - 1) / clk_period_ns;
  localparam int unsigned oe_high_cyc = (oe_high_ns + clk_period_ns - 1) / clk_period_ns;
  localparam int unsigned rd_access_cyc = (rd_access_ns + clk_period_ns - 1) / clk_period_ns + 1;
  // worst-case busy times
  localparam int unsigned prog_max_us = 50;
  localparam int unsigned erase_max_s = 5;
  localparam longint unsigned prog_max_cyc = (64'(prog_max_us) * 1000) / clk_period_ns;
  localparam longint unsigned erase_max_cyc = (64'(erase_max_s) * 1000000000) / clk_period_ns;
  // command words and addresses on a14..a0
  localparam logic [14:0] unlock_addr_a = 15'h5555;
  localparam logic [14:0] unlock_addr_b = 15'h2aaa;
  localparam logic [14:0] chip_erase_addr = 15'h0555;
  localparam logic [7:0] unlock_data_a = 8'haa;
  localparam logic [7:0] unlock_data_b = 8'h55;
  localparam logic [7:0] cmd_program = 8'ha0;
  localparam logic [7:0] cmd_erase_setup = 8'h80;
  localparam logic [7:0] cmd_chip_erase = 8'h10;
  localparam logic [7:0] cmd_sector_erase = 8'h30;
  localparam logic [7:0] cmd_id_entry = 8'h90;
  localparam logic [7:0] cmd_id_exit = 8'hf0;
  localparam logic [7:0] cmd_lockout = 8'h40;
  localparam logic [16:0] id_extra_addr = 17'h00003;
  localparam int unsigned toggle_bit = 6;
  // host operations
  typedef enum logic [2:0] {
    fps_op_read, fps_op_program, fps_op_chip_erase, fps_op_sector_erase,
    fps_op_id_entry, fps_op_id_exit, fps_op_lockout
  } fps_op_t;
  // result codes
  localparam logic [1:0] res_ok = 2'h0;
  localparam logic [1:0] res_timeout = 2'h1;
endpackage

// ==== verilog/fps_sync.sv ====
// three-stage input synchroniser with agreement on the last two stages
`timescale 1ns/1ps
module fps_sync #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // raw and cleaned
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1_q, s2_q, s3_q, out_q;
  logic [W-1:0] out_d;

  // take a bit only where the second and third stage agree
  always_comb
  begin
    out_d = out_q;
    for (int i = 0; i < W; i++)
    begin
      if (s2_q[i] == s3_q[i])
        out_d[i] = s3_q[i];
    end
  end

  // register stages
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      out_q <= '0;
    end
    else
    begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      out_q <= out_d;
    end
  end

  assign dout = out_q;
endmodule

// ==== verilog/fps_host.sv ====
// host sequencer driving a byte-wide parallel flash through its pins
// Notes on behaviour
// RULE_01 - program busy at most 50 us, then timeout
// RULE_02 - erase busy at most 5 s, then timeout
// RULE_03 - chip erase final write at address 555
// RULE_04 - final erase data 10h chip, 30h sector
// RULE_05 - output gate high whenever select and strobe low
// RULE_06 - each gate toggle flips status toggle line
// RULE_07 - poll address stays constant through poll
// RULE_08 - only change between reads means busy
// RULE_09 - id reads: low address bit selects code
// RULE_10 - id read at 0003h gives extra code
// RULE_11 - power loss leaves id mode
// RULE_12 - id exit sequence returns array reads
// RULE_13 - commands decoded on a14..a0, bytes
// RULE_14 - lockout sequence protects boot block
// RULE_15 - no commands while device is busy; after a timeout the host takes new requests without checking busy
// RULE_16 - full unlock sequence before each command
`timescale 1ns/1ps
module fps_host
  import fps_pkg::*;
#(
  parameter longint unsigned prog_timeout = prog_max_cyc,
  parameter longint unsigned erase_timeout = erase_max_cyc
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // user request
  input wire logic req,
  input wire fps_op_t req_op,
  input wire logic [16:0] req_addr,
  input wire logic [7:0] req_data,
  output logic req_ready,
  output logic done,
  output logic [7:0] rd_data,
  output logic [1:0] result,
  // flash pins
  output logic [16:0] fl_addr,
  output logic fl_ce_n,
  output logic fl_oe_n,
  output logic fl_we_n,
  output logic [7:0] fl_dq_o,
  output logic fl_dq_oe,
  input wire logic [7:0] fl_dq_i
);
  typedef enum logic [3:0] {
    st_idle, st_wr_setup, st_wr_pulse, st_wr_high, st_next,
    st_rd_setup, st_rd_wait, st_rd_take, st_poll_gap, st_finish
  } fps_state_t;

  fps_state_t state_q, state_d;
  fps_op_t op_q, op_d;
  logic [2:0] step_q, step_d, nsteps_q, nsteps_d;
  logic [16:0] addr_q, addr_d, fa_q, fa_d;
  logic [7:0] data_q, data_d, fd_q, fd_d, rdat_q, rdat_d, dq_s;
  logic ce_q, ce_d, oe_q, oe_d, we_q, we_d, dqoe_q, dqoe_d;
  logic [3:0] tim_q, tim_d;
  logic [27:0] busy_q, busy_d;
  logic poll_q, poll_d, have_prev_q, have_prev_d, prev_q, prev_d, ready_q, ready_d, done_q, done_d;
  logic [1:0] res_q, res_d;

  fps_sync #(.W(8)) u_sync (
    .mclk(mclk),
    .rst(rst),
    .din(fl_dq_i),
    .dout(dq_s)
  );
  // address and data of each write step of the command sequence
  function automatic logic [24:0] seq_word(input fps_op_t op, input logic [2:0] s,
                                           input logic [16:0] a, input logic [7:0] d);
    logic [7:0] c;
    case (op)
      fps_op_program: c = cmd_program;
      fps_op_id_entry: c = cmd_id_entry;
      fps_op_id_exit: c = cmd_id_exit;
      fps_op_lockout: c = cmd_lockout;
      default: c = cmd_erase_setup;
    endcase
    case (s)
      3'h0: seq_word = {2'h0, unlock_addr_a, unlock_data_a}; // RULE_16 RULE_13
      3'h1, 3'h4: seq_word = {2'h0, unlock_addr_b, unlock_data_b}; // RULE_16
      3'h2: seq_word = {2'h0, unlock_addr_a, c};
      // fourth write is the data byte for a program, a second unlock for an erase
      3'h3: seq_word = (op == fps_op_program) ? {a, d} : {2'h0, unlock_addr_a, unlock_data_a}; // RULE_16
      default:
      begin
        if (op == fps_op_chip_erase)
          seq_word = {2'h0, chip_erase_addr, cmd_chip_erase}; // RULE_03 RULE_04
        else
          seq_word = {a, cmd_sector_erase}; // RULE_03 RULE_04
      end
    endcase
  endfunction

  // main sequencer
  always_comb
  begin
    logic [24:0] w;
    w = seq_word(op_q, step_q, addr_q, data_q);
    state_d = state_q;
    op_d = op_q;
    step_d = step_q;
    nsteps_d = nsteps_q;
    addr_d = addr_q;
    data_d = data_q;
    fa_d = fa_q;
    fd_d = fd_q;
    ce_d = ce_q;
    oe_d = oe_q;
    we_d = we_q;
    dqoe_d = dqoe_q;
    tim_d = (tim_q != 4'h0) ? tim_q - 4'h1 : 4'h0;
    busy_d = busy_q + 28'h1;
    poll_d = poll_q;
    have_prev_d = have_prev_q;
    prev_d = prev_q;
    ready_d = ready_q;
    done_d = 1'b0;
    rdat_d = rdat_q;
    res_d = res_q;
    case (state_q)
      st_idle:
      begin
        ready_d = 1'b1;
        if (req && ready_q)
        begin
          ready_d = 1'b0; // RULE_15
          op_d = req_op;
          addr_d = req_addr;
          data_d = req_data;
          step_d = 3'h0;
          poll_d = 1'b0;
          res_d = res_ok;
          case (req_op)
            fps_op_read: state_d = st_rd_setup;
            fps_op_program: nsteps_d = 3'h4;
            fps_op_chip_erase, fps_op_sector_erase: nsteps_d = 3'h6;
            default: nsteps_d = 3'h3; // RULE_16 RULE_12 RULE_14
          endcase
          if (req_op != fps_op_read)
            state_d = st_wr_setup;
        end
      end
      st_wr_setup:
      begin
        fa_d = w[24:8];
        fd_d = w[7:0];
        dqoe_d = 1'b1;
        oe_d = 1'b1; // RULE_05
        state_d = st_wr_pulse;
        ce_d = 1'b0;
        we_d = 1'b0;
        tim_d = 4'(wr_pulse_cyc);
      end
      st_wr_pulse:
        if (tim_q <= 4'h1)
        begin
          we_d = 1'b1;
          ce_d = 1'b1;
          tim_d = 4'(wr_high_cyc);
          state_d = st_wr_high;
        end
      st_wr_high:
        if (tim_q <= 4'h1)
        begin
          dqoe_d = 1'b0;
          state_d = st_next;
        end
      st_next:
        if (step_q + 3'h1 < nsteps_q)
        begin
          step_d = step_q + 3'h1;
          state_d = st_wr_setup;
        end
        else if (op_q == fps_op_program || op_q == fps_op_chip_erase || op_q == fps_op_sector_erase)
        begin
          poll_d = 1'b1; // RULE_07
          have_prev_d = 1'b0;
          busy_d = 28'h0;
          if (op_q == fps_op_chip_erase)
            addr_d = 17'h0;
          state_d = st_rd_setup;
        end
        else
          state_d = st_finish;
      st_rd_setup:
      begin
        fa_d = addr_q; // RULE_07 RULE_09 RULE_10
        dqoe_d = 1'b0;
        ce_d = 1'b0;
        oe_d = 1'b0;
        tim_d = 4'(rd_access_cyc + 3);
        state_d = st_rd_wait;
      end
      st_rd_wait:
        if (tim_q <= 4'h1)
          state_d = st_rd_take;
      st_rd_take:
      begin
        ce_d = 1'b1; // RULE_06
        oe_d = 1'b1;
        rdat_d = dq_s;
        tim_d = 4'(oe_high_cyc + 1);
        if (!poll_q)
          state_d = st_finish;
        else if (have_prev_q && prev_q == dq_s[toggle_bit])
          state_d = st_finish; // RULE_08
        else if ((op_q == fps_op_program && 64'(busy_q) >= prog_timeout) ||
                 (op_q != fps_op_program && 64'(busy_q) >= erase_timeout))
        begin
          res_d = res_timeout; // RULE_01 RULE_02
          state_d = st_finish;
        end
        else
        begin
          have_prev_d = 1'b1;
          prev_d = dq_s[toggle_bit];
          state_d = st_poll_gap;
        end
      end
      st_poll_gap:
        if (tim_q <= 4'h1)
          state_d = st_rd_setup;
      st_finish:
      begin
        done_d = 1'b1;
        ready_d = 1'b1;
        state_d = st_idle;
      end
      default:
        state_d = st_idle;
    endcase
  end
  // registers
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= st_idle;
      op_q <= fps_op_read;
      step_q <= 3'h0;
      nsteps_q <= 3'h0;
      addr_q <= 17'h0;
      data_q <= 8'h00;
      fa_q <= 17'h0;
      fd_q <= 8'h00;
      ce_q <= 1'b1;
      oe_q <= 1'b1;
      we_q <= 1'b1;
      dqoe_q <= 1'b0;
      tim_q <= 4'h0;
      busy_q <= 28'h0;
      poll_q <= 1'b0;
      have_prev_q <= 1'b0;
      prev_q <= 1'b0;
      ready_q <= 1'b0;
      done_q <= 1'b0;
      rdat_q <= 8'h00;
      res_q <= res_ok;
    end
    else
    begin
      state_q <= state_d;
      op_q <= op_d;
      step_q <= step_d;
      nsteps_q <= nsteps_d;
      addr_q <= addr_d;
      data_q <= data_d;
      fa_q <= fa_d;
      fd_q <= fd_d;
      ce_q <= ce_d;
      oe_q <= oe_d;
      we_q <= we_d;
      dqoe_q <= dqoe_d;
      tim_q <= tim_d;
      busy_q <= busy_d;
      poll_q <= poll_d;
      have_prev_q <= have_prev_d;
      prev_q <= prev_d;
      ready_q <= ready_d;
      done_q <= done_d;
      rdat_q <= rdat_d;
      res_q <= res_d;
    end
  end

  // pin and user outputs straight from flip-flops
  assign req_ready = ready_q;
  assign done = done_q;
  assign rd_data = rdat_q;
  assign result = res_q;
  assign fl_addr = fa_q;
  assign fl_ce_n = ce_q;
  assign fl_oe_n = oe_q;
  assign fl_we_n = we_q;
  assign fl_dq_o = fd_q;
  assign fl_dq_oe = dqoe_q;
endmodule

// ==== bench/fps_host_sva.sv ====
// port assertions for the flash host sequencer
`timescale 1ns/1ps
module fps_host_sva
  import fps_pkg::*;
#(
  parameter longint unsigned prog_timeout = prog_max_cyc,
  parameter longint unsigned erase_timeout = erase_max_cyc
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // user side
  input wire logic req,
  input wire fps_op_t req_op,
  input wire logic [16:0] req_addr,
  input wire logic [7:0] req_data,
  input wire logic req_ready,
  input wire logic done,
  input wire logic [7:0] rd_data,
  input wire logic [1:0] result,
  // flash pins
  input wire logic [16:0] fl_addr,
  input wire logic fl_ce_n,
  input wire logic fl_oe_n,
  input wire logic fl_we_n,
  input wire logic [7:0] fl_dq_o,
  input wire logic fl_dq_oe,
  input wire logic [7:0] fl_dq_i
);
  fps_op_t op_d, op_q;
  logic [16:0] addr_d, addr_q;
  logic [31:0] cnt_d, cnt_q;
  // latch the taken operation and count its cycles
  always_comb
  begin
    op_d = op_q;
    addr_d = addr_q;
    cnt_d = cnt_q + 32'h1;
    if (req && req_ready)
    begin
      op_d = req_op;
      addr_d = req_addr;
      cnt_d = 32'h0;
    end
  end
  // helper registers
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      op_q <= fps_op_read;
      addr_q <= 17'h0;
      cnt_q <= 32'h0;
    end
    else
    begin
      op_q <= op_d;
      addr_q <= addr_d;
      cnt_q <= cnt_d;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  oe_guard_a: assert property (!fl_ce_n && !fl_we_n |-> fl_oe_n)
    else $error("gate low during write strobe");
  take_busy_a: assert property (req && req_ready |=> !req_ready [*3])
    else $error("request taken while busy");
  write_drive_a: assert property (!fl_we_n |-> fl_dq_oe)
    else $error("write strobe without data driven");
  read_float_a: assert property (!fl_oe_n |-> !fl_dq_oe)
    else $error("host drives bus during read");
  poll_addr_a: assert property (!fl_oe_n && !$past(fl_oe_n) |-> $stable(fl_addr))
    else $error("address moved during read");
  prog_bound_a: assert property (done && op_q == fps_op_program |-> cnt_q < prog_timeout + 200)
    else $error("program wait too long");
  erase_bound_a: assert property (done && op_q inside {fps_op_chip_erase, fps_op_sector_erase} |->
    cnt_q < erase_timeout + 200) else $error("erase wait too long");
  chip_word_a: assert property (!fl_we_n && op_q == fps_op_chip_erase && fl_dq_o == cmd_chip_erase
    |-> fl_addr[14:0] == chip_erase_addr) else $error("chip erase word at wrong address");
  sector_word_a: assert property (!fl_we_n && op_q == fps_op_sector_erase && fl_addr == addr_q
    |-> fl_dq_o == cmd_sector_erase) else $error("sector erase word wrong");
  poll_target_a: assert property (!fl_oe_n && op_q inside {fps_op_program, fps_op_sector_erase}
    |-> fl_addr == addr_q) else $error("poll read away from target address");
  unlock_first_a: assert property (req && req_ready && req_op != fps_op_read |-> ##2
    (!fl_we_n && fl_addr[14:0] == unlock_addr_a && fl_dq_o == unlock_data_a)) else $error("first unlock word wrong");
endmodule
bind fps_host fps_host_sva #(.prog_timeout(prog_timeout), .erase_timeout(erase_timeout)) i_sva (
  .mclk(mclk), .rst(rst), .req(req), .req_op(req_op), .req_addr(req_addr), .req_data(req_data),
  .req_ready(req_ready), .done(done), .rd_data(rd_data), .result(result), .fl_addr(fl_addr),
  .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n), .fl_dq_o(fl_dq_o), .fl_dq_oe(fl_dq_oe),
  .fl_dq_i(fl_dq_i));

// ==== bench/fps_flash_model.sv ====
// behavioural parallel flash seen at the host pins
`timescale 1ns/1ps
module fps_flash_model
  import fps_pkg::*;
#(
  parameter logic [7:0] mfr_code = 8'h3c, // arbitrary value
  parameter logic [7:0] part_code = 8'h71, // arbitrary value
  parameter logic [7:0] extra_code = 8'h2e, // arbitrary value
  parameter int prog_ns = 5000,
  parameter int erase_ns = 50000,
  parameter int boot_top = 16384
) (
  // pins
  input wire logic [16:0] addr,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [7:0] dq_in,
  output logic [7:0] dq_out,
  // slow answer control and busy view
  input wire logic slow,
  output logic busy
);
  logic [7:0] mem [0:131071];
  logic id_q = 1'b0; // powers up in array read
  logic lock_q = 1'b0;
  logic tog = 1'b0;
  logic [7:0] rd_v;
  int st = 0;
  wire [14:0] a15 = addr[14:0];
  wire drv = !ce_n && !oe_n;
  initial
  begin
    foreach (mem[i]) mem[i] = 8'hff;
    busy = 1'b0;
    dq_out = 8'h00;
  end
  // internal timer; blocking here also drops commands meanwhile
  task automatic run_busy(input int ns);
    busy = 1'b1;
    #(slow ? ns * 6 : ns);
    busy = 1'b0;
  endtask
  // command decoder, sampled just after the strobe falls
  always @(negedge we_n)
  begin
    #1;
    if (!ce_n)
    begin
      case (st)
        0, 4: st = (a15 == unlock_addr_a && dq_in == unlock_data_a) ? st + 1 : 0;
        1, 5: st = (a15 == unlock_addr_b && dq_in == unlock_data_b) ? st + 1 : 0;
        2:
        begin
          st = (a15 != unlock_addr_a) ? 0 : (dq_in == cmd_program) ? 3 : (dq_in == cmd_erase_setup) ? 4 : 0;
          if (a15 == unlock_addr_a && dq_in == cmd_id_entry) id_q = 1'b1;
          if (a15 == unlock_addr_a && dq_in == cmd_id_exit) id_q = 1'b0;
          if (a15 == unlock_addr_a && dq_in == cmd_lockout) lock_q = 1'b1;
        end
        3:
        begin
          st = 0;
          if (!(lock_q && addr < boot_top)) mem[addr] = dq_in;
          run_busy(prog_ns);
        end
        6:
        begin
          st = 0;
          for (int i = 0; i < 131072; i++)
            if (!(lock_q && i < boot_top) && ((dq_in == cmd_chip_erase && a15 == chip_erase_addr) ||
                (dq_in == cmd_sector_erase && i[16:14] == addr[16:14]))) mem[i] = 8'hff;
          run_busy(erase_ns);
        end
        default: st = 0;
      endcase
    end
  end
  // one flip per read while busy, whichever input toggles
  always @(posedge drv) if (busy) tog = ~tog;
  // status while busy, else id codes or array
  always @*
    rd_v = busy ? {1'b0, tog, 6'h15} : !id_q ? mem[addr] : addr == 17'h0 ? mfr_code :
      addr == 17'h1 ? part_code : addr == id_extra_addr ? extra_code : 8'hff;
  // released bus shows the inverse of the last byte
  always @(drv or rd_v) if (drv) dq_out = rd_v;
  always @(negedge drv) dq_out = ~dq_out;
endmodule

// ==== bench/testbench.sv ====
// self-checking bench for the flash host sequencer
`timescale 1ns/1ps
module testbench;
  import fps_pkg::*;
  typedef struct packed {fps_op_t op; logic [16:0] a; logic [7:0] d; logic [7:0] e;} fps_row_t;
  logic mclk, rst, req, req_ready, done, fl_ce_n, fl_oe_n, fl_we_n, fl_dq_oe, slow, busy;
  logic [16:0] req_addr, fl_addr;
  logic [7:0] req_data, rd_data, fl_dq_o, mdl_q;
  logic [1:0] result;
  fps_op_t req_op;
  wire [7:0] bus = fl_dq_oe ? fl_dq_o : mdl_q;
  int failures, total_checks, cyc;
  fps_row_t rows [19] = '{
    '{fps_op_program, 17'h08100, 8'h5a, 8'h0}, '{fps_op_read, 17'h08100, 8'h0, 8'h5a},
    '{fps_op_id_entry, 17'h0, 8'h0, 8'h0}, '{fps_op_read, 17'h0, 8'h0, 8'h3c},
    '{fps_op_read, 17'h1, 8'h0, 8'h71}, '{fps_op_read, 17'h3, 8'h0, 8'h2e},
    '{fps_op_id_exit, 17'h0, 8'h0, 8'h0}, '{fps_op_read, 17'h08100, 8'h0, 8'h5a},
    '{fps_op_sector_erase, 17'h08100, 8'h0, 8'h0}, '{fps_op_read, 17'h08100, 8'h0, 8'hff},
    '{fps_op_program, 17'h00200, 8'ha5, 8'h0}, '{fps_op_read, 17'h00200, 8'h0, 8'ha5},
    '{fps_op_lockout, 17'h0, 8'h0, 8'h0}, '{fps_op_program, 17'h00300, 8'h11, 8'h0},
    '{fps_op_read, 17'h00300, 8'h0, 8'hff}, '{fps_op_program, 17'h09000, 8'h77, 8'h0},
    '{fps_op_chip_erase, 17'h0, 8'h0, 8'h0}, '{fps_op_read, 17'h09000, 8'h0, 8'hff},
    '{fps_op_read, 17'h00200, 8'h0, 8'ha5}};
  fps_host #(.prog_timeout(200), .erase_timeout(2000)) i_dut (.mclk(mclk), .rst(rst), .req(req),
    .req_op(req_op), .req_addr(req_addr), .req_data(req_data), .req_ready(req_ready), .done(done),
    .rd_data(rd_data), .result(result), .fl_addr(fl_addr), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n),
    .fl_we_n(fl_we_n), .fl_dq_o(fl_dq_o), .fl_dq_oe(fl_dq_oe), .fl_dq_i(bus));
  fps_flash_model i_flash (.addr(fl_addr), .ce_n(fl_ce_n), .oe_n(fl_oe_n), .we_n(fl_we_n),
    .dq_in(bus), .dq_out(mdl_q), .slow(slow), .busy(busy));
  // compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one request, then a bounded wait for done
  task automatic run(input fps_row_t r);
    int n;
    @(posedge mclk);
    req <= 1'b1;
    req_op <= r.op;
    req_addr <= r.a;
    req_data <= r.d;
    @(posedge mclk);
    req <= 1'b0;
    for (n = 0; n < 6000 && done !== 1'b1; n++) @(posedge mclk) #1;
    check({7'h0, done}, 8'h01);
  endtask
  // report and end the run
  task automatic stop_test;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // clock
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // hang guard
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      failures++;
      stop_test();
    end
  end
  // main sequence
  initial
  begin
    rst = 1'b1;
    req = 1'b0;
    req_op = fps_op_read;
    req_addr = 17'h0;
    req_data = 8'h0;
    slow = 1'b0;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    foreach (rows[i])
    begin
      run(rows[i]);
      if (rows[i].op == fps_op_read) check(rd_data, rows[i].e);
      check({6'h0, result}, {6'h0, res_ok});
    end
    // slow device: program outlasts the limit
    slow <= 1'b1;
    run('{fps_op_program, 17'h09200, 8'h11, 8'h0});
    check({6'h0, result}, {6'h0, res_timeout});
    slow <= 1'b0;
    for (int n = 0; n < 2000 && busy === 1'b1; n++) @(posedge mclk);
    // reset in mid-read, then recover
    @(posedge mclk);
    req <= 1'b1;
    req_op <= fps_op_read;
    @(posedge mclk);
    req <= 1'b0;
    repeat (3) @(posedge mclk);
    rst <= 1'b1;
    @(posedge mclk) #1;
    check({4'h0, fl_ce_n, fl_oe_n, fl_we_n, req_ready}, 8'h0e);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    run('{fps_op_read, 17'h00200, 8'h0, 8'h0});
    check(rd_data, 8'ha5);
    stop_test();
  end
endmodule
